// ==== src/fwec_map.svh ====
`ifndef FWEC_MAP_SVH
`define FWEC_MAP_SVH

// special register addresses (page selects the window for the level pair)
`define FWEC_ADDR_LVL_LOW   8'h93
`define FWEC_ADDR_LVL_HIGH  8'h94
`define FWEC_ADDR_PAGE      8'hA7
`define FWEC_ADDR_KEY       8'hB7
`define FWEC_ADDR_PROGRAM_STORE_CONTROL     8'h8F
`define FWEC_ADDR_SCALE     8'hB6
`define FWEC_ADDR_RESET_SOURCE_REGISTER    8'hEF
`define FWEC_PAGE_LVL       8'h01

// field positions
`define FWEC_PROGRAM_STORE_CONTROL_WE_BIT   0
`define FWEC_PROGRAM_STORE_CONTROL_EE_BIT   1
`define FWEC_SCALE_WT_BIT   4
`define FWEC_RST_MON_BIT    1
`define FWEC_STAT_LOCK_BIT  0
`define FWEC_STAT_OUT_BIT   1

// key codes and values
`define FWEC_KEY_FIRST      8'hA5
`define FWEC_KEY_SECOND     8'hF1
`define FWEC_ERASED_BYTE    8'hFF
`define FWEC_SHORT_LIMIT    16'h00FF

// reset values
`define FWEC_RST_LVL_LOW    8'h40
`define FWEC_RST_LVL_HIGH   8'h80
`define FWEC_RST_ZERO       8'h00

// timing: write time in ns, erase time in us, clock period in ns
`define FWEC_CLK_NS         5
`define FWEC_WRITE_NS       20000
`define FWEC_ERASE_US       20000
`define FWEC_CAL_CYCLES     16

`endif

// ==== src/fwec_pkg.sv ====
package fwec_pkg;
	typedef enum logic [1:0] {
		FWEC_LOCKED,
		FWEC_FIRST_SEEN,
		FWEC_UNLOCKED,
		FWEC_LOCKOUT
	} fwec_lock_t;

	typedef enum logic [1:0] {
		FWEC_IDLE,
		FWEC_WRITE,
		FWEC_ERASE
	} fwec_op_t;
endpackage : fwec_pkg

// ==== src/fwec_op_timer.sv ====
`include "fwec_map.svh"

// counts one flash operation down and pulses done at its end
module fwec_op_timer
	import fwec_pkg::*;
#(
	parameter int CW = 24
) (
	input  wire logic          core_clk_in,
	input  wire logic          nrst_in,
	input  wire logic          start_in,
	input  wire logic [CW-1:0] cycles_in,
	output logic               busy_out,
	output logic               done_out
);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic          busy_ff;
	logic          nxt_busy;
	logic          done_ff;
	logic          nxt_done;

	// load on start, count down, flag the last cycle
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (start_in && !busy_ff) begin
			nxt_cnt  = cycles_in;
			nxt_busy = 1'b1;
		end else if (busy_ff) begin
			if (cnt_ff <= CW'(1)) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				nxt_cnt  = '0;
			end else begin
				nxt_cnt = cnt_ff - CW'(1);
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			cnt_ff  <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign busy_out = busy_ff;
	assign done_out = done_ff;
endmodule : fwec_op_timer

// ==== src/fwec_ctrl.sv ====
// Overview of operation
// - flash written one byte per operation
// - writes only clear bits; erase gives FF
// - hardware times each write and erase
// - core stalled for whole flash operation
// - uninitialised part programmable only by debug
// - short-address writes limited to 0x00FF
// - regulator calibrated after every reset
// - high threshold non-power reset holds reset when reg_lo_cal_in is high
// - power-on reset restores low threshold
// - key codes A5 then F1 required
// - any gap allowed between key codes
// - wrong key locks out until reset
// - operation while locked locks out too
// - lock closes at launch of every software operation
// - write enable steers moves to flash
// - pages of 512 bytes, erased whole
// - erase enable plus write erases page
`include "fwec_map.svh"

module fwec_ctrl
	import fwec_pkg::*;
#(
	parameter int AW           = 17,
	parameter int PAGE_BYTES   = 512,
	parameter int WRITE_CYCLES = (`FWEC_WRITE_NS + `FWEC_CLK_NS - 1) / `FWEC_CLK_NS,
	parameter int ERASE_CYCLES = (`FWEC_ERASE_US * 1000 + `FWEC_CLK_NS - 1) / `FWEC_CLK_NS
) (
	input  wire logic          core_clk_in,
	input  wire logic          nrst_in,
	input  wire logic          por_in,
	input  wire logic          initialized_in,
	input  wire logic          reg_lo_cal_in,
	input  wire logic          sfr_wr_in,
	input  wire logic [7:0]    sfr_addr_in,
	input  wire logic [7:0]    sfr_wdata_in,
	input  wire logic [7:0]    sfr_rd_addr_in,
	output logic      [7:0]    sfr_rdata_out,
	input  wire logic          mov_wr_in,
	input  wire logic          mov_short_in,
	input  wire logic [AW-1:0] mov_addr_in,
	input  wire logic [7:0]    mov_data_in,
	input  wire logic          dbg_wr_in,
	input  wire logic          dbg_erase_in,
	input  wire logic [AW-1:0] dbg_addr_in,
	input  wire logic [7:0]    dbg_data_in,
	input  wire logic [7:0]    flash_rdata_in,
	output logic               flash_wr_out,
	output logic               flash_erase_out,
	output logic      [AW-1:0] flash_addr_out,
	output logic      [7:0]    flash_wdata_out,
	output logic               ram_wr_out,
	output logic               stall_out,
	output logic               hold_reset_out,
	output logic               mon_high_out
);
	localparam int CW = 32;

	fwec_lock_t    lock_ff;
	fwec_lock_t    nxt_lock;
	fwec_op_t      op_ff;
	fwec_op_t      nxt_op;
	logic [7:0]    program_store_control_ff, nxt_program_store_control;
	logic [7:0]    scale_ff, nxt_scale;
	logic [7:0]    page_ff, nxt_page;
	logic [7:0]    lvl_lo_ff, nxt_lvl_lo;
	logic [7:0]    lvl_hi_ff, nxt_lvl_hi;
	logic [7:0]    reset_source_register_ff, nxt_reset_source_register;
	logic          mon_high_ff, nxt_mon_high;
	logic          hold_ff, nxt_hold;
	logic [4:0]    cal_ff, nxt_cal;
	logic          lo_s1_ff, lo_s2_ff;
	logic          init_s1_ff, init_s2_ff;
	logic [AW-1:0] addr_ff, nxt_addr;
	logic [7:0]    data_ff, nxt_data;
	logic          start;
	logic [CW-1:0] op_cycles;
	logic          busy;
	logic          done;
	logic          sw_req;
	logic          key_wr;
	logic          cal_busy;

	assign key_wr   = sfr_wr_in && sfr_addr_in == `FWEC_ADDR_KEY;
	assign cal_busy = cal_ff != 5'h00;

	// pin-side levels pass two flops
	always_ff @(posedge core_clk_in) begin
		lo_s1_ff   <= reg_lo_cal_in;
		lo_s2_ff   <= lo_s1_ff;
		init_s1_ff <= initialized_in;
		init_s2_ff <= init_s1_ff;
	end

	// software flash write request, gated by enables and short range
	always_comb begin
		sw_req = mov_wr_in && program_store_control_ff[`FWEC_PROGRAM_STORE_CONTROL_WE_BIT] && init_s2_ff;
		if (mov_short_in && {{(32-AW){1'b0}}, mov_addr_in} > 32'(`FWEC_SHORT_LIMIT))
			sw_req = 1'b0;
	end

	// lock machine and operation launch
	always_comb begin
		nxt_lock = lock_ff;
		nxt_op   = op_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		start    = 1'b0;
		if (done) begin
			nxt_op = FWEC_IDLE;
		end
		if (key_wr && lock_ff != FWEC_LOCKOUT) begin
			unique case (lock_ff)
				FWEC_LOCKED: nxt_lock = (sfr_wdata_in == `FWEC_KEY_FIRST) ?
					FWEC_FIRST_SEEN : FWEC_LOCKOUT;
				FWEC_FIRST_SEEN: nxt_lock = (sfr_wdata_in == `FWEC_KEY_SECOND) ?
					FWEC_UNLOCKED : FWEC_LOCKOUT;
				default: nxt_lock = FWEC_LOCKOUT;
			endcase
		end else if (op_ff == FWEC_IDLE && !busy && sw_req) begin
			if (lock_ff == FWEC_UNLOCKED) begin
				start    = 1'b1;
				nxt_lock = FWEC_LOCKED;
				nxt_addr = mov_addr_in;
				nxt_data = mov_data_in;
				nxt_op   = program_store_control_ff[`FWEC_PROGRAM_STORE_CONTROL_EE_BIT] ? FWEC_ERASE : FWEC_WRITE;
			end else begin
				nxt_lock = FWEC_LOCKOUT;
			end
		end else if (op_ff == FWEC_IDLE && !busy && (dbg_wr_in || dbg_erase_in)) begin
			start    = 1'b1;
			nxt_addr = dbg_addr_in;
			nxt_data = dbg_data_in;
			nxt_op   = dbg_erase_in ? FWEC_ERASE : FWEC_WRITE;
		end
		op_cycles = (nxt_op == FWEC_ERASE) ? CW'(ERASE_CYCLES) : CW'(WRITE_CYCLES);
	end

	// control, scale, page, level and reset-source registers
	always_comb begin
		nxt_program_store_control    = program_store_control_ff;
		nxt_scale    = scale_ff;
		nxt_page     = page_ff;
		nxt_lvl_lo   = lvl_lo_ff;
		nxt_lvl_hi   = lvl_hi_ff;
		nxt_reset_source_register   = reset_source_register_ff;
		nxt_mon_high = mon_high_ff;
		if (sfr_wr_in) begin
			unique case (sfr_addr_in)
				`FWEC_ADDR_PROGRAM_STORE_CONTROL:  nxt_program_store_control  = sfr_wdata_in & 8'h03;
				`FWEC_ADDR_SCALE:  nxt_scale  = sfr_wdata_in;
				`FWEC_ADDR_PAGE:   nxt_page   = sfr_wdata_in;
				`FWEC_ADDR_RESET_SOURCE_REGISTER: nxt_reset_source_register = sfr_wdata_in;
				`FWEC_ADDR_LVL_LOW:
					if (page_ff == `FWEC_PAGE_LVL) nxt_lvl_lo = sfr_wdata_in;
					else nxt_mon_high = sfr_wdata_in[7];
				`FWEC_ADDR_LVL_HIGH:
					if (page_ff == `FWEC_PAGE_LVL) nxt_lvl_hi = sfr_wdata_in;
				default: ;
			endcase
		end
	end

	// calibration after every reset and high-threshold reset hold
	always_comb begin
		nxt_cal  = cal_busy ? cal_ff - 5'h01 : cal_ff;
		nxt_hold = hold_ff;
		if (por_in) nxt_hold = 1'b0;
	end

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			lock_ff   <= FWEC_LOCKED;
			op_ff     <= FWEC_IDLE;
			addr_ff   <= '0;
			data_ff   <= `FWEC_RST_ZERO;
			program_store_control_ff  <= `FWEC_RST_ZERO;
			scale_ff  <= `FWEC_RST_ZERO;
			page_ff   <= `FWEC_RST_ZERO;
			reset_source_register_ff <= `FWEC_RST_ZERO;
			cal_ff    <= 5'(`FWEC_CAL_CYCLES);
		end else begin
			lock_ff   <= nxt_lock;
			op_ff     <= nxt_op;
			addr_ff   <= nxt_addr;
			data_ff   <= nxt_data;
			program_store_control_ff  <= nxt_program_store_control;
			scale_ff  <= nxt_scale;
			page_ff   <= nxt_page;
			reset_source_register_ff <= nxt_reset_source_register;
			cal_ff    <= nxt_cal;
		end
	end

	// monitor state survives non-power resets; power-on restores low
	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			mon_high_ff <= 1'b0;
			hold_ff     <= 1'b0;
			lvl_lo_ff   <= `FWEC_RST_LVL_LOW;
			lvl_hi_ff   <= `FWEC_RST_LVL_HIGH;
		end else if (!nrst_in) begin
			mon_high_ff <= mon_high_ff;
			hold_ff     <= hold_ff | (mon_high_ff & lo_s2_ff);
			lvl_lo_ff   <= lvl_lo_ff;
			lvl_hi_ff   <= lvl_hi_ff;
		end else begin
			mon_high_ff <= nxt_mon_high;
			hold_ff     <= nxt_hold;
			lvl_lo_ff   <= nxt_lvl_lo;
			lvl_hi_ff   <= nxt_lvl_hi;
		end
	end

	fwec_op_timer #(.CW(CW)) u_timer (
		.core_clk_in (core_clk_in),
		.nrst_in     (nrst_in),
		.start_in    (start),
		.cycles_in   (op_cycles),
		.busy_out    (busy),
		.done_out    (done)
	);

	// register readback
	always_comb begin
		unique case (sfr_rd_addr_in)
			`FWEC_ADDR_PROGRAM_STORE_CONTROL:    sfr_rdata_out = program_store_control_ff;
			`FWEC_ADDR_SCALE:    sfr_rdata_out = scale_ff;
			`FWEC_ADDR_PAGE:     sfr_rdata_out = page_ff;
			`FWEC_ADDR_RESET_SOURCE_REGISTER:   sfr_rdata_out = reset_source_register_ff;
			`FWEC_ADDR_KEY:      sfr_rdata_out = {6'h00, lock_ff == FWEC_LOCKOUT,
				lock_ff == FWEC_UNLOCKED};
			`FWEC_ADDR_LVL_LOW:  sfr_rdata_out = page_ff == `FWEC_PAGE_LVL ? lvl_lo_ff
				: {mon_high_ff, 7'h00};
			`FWEC_ADDR_LVL_HIGH: sfr_rdata_out = page_ff == `FWEC_PAGE_LVL ? lvl_hi_ff
				: 8'h00;
			default:             sfr_rdata_out = 8'h00;
		endcase
	end

	// flash array strobes; write data ANDed with the old byte
	assign flash_wr_out    = op_ff == FWEC_WRITE && done;
	assign flash_erase_out = op_ff == FWEC_ERASE && done;
	assign flash_addr_out  = (op_ff == FWEC_ERASE) ?
		(addr_ff & ~AW'(PAGE_BYTES - 1)) : addr_ff;
	assign flash_wdata_out = (op_ff == FWEC_ERASE) ? `FWEC_ERASED_BYTE
		: (data_ff & flash_rdata_in);
	assign ram_wr_out      = mov_wr_in && !program_store_control_ff[`FWEC_PROGRAM_STORE_CONTROL_WE_BIT];
	assign stall_out       = op_ff != FWEC_IDLE || cal_busy;
	assign hold_reset_out  = hold_ff;
	assign mon_high_out    = mon_high_ff;
endmodule : fwec_ctrl

// ==== sim/fwec_flash_model.sv ====
// flash array seen from the controller: comb read, and-commit, page erase
module fwec_flash_model #(
	parameter int AW = 17
) (
	input  wire logic          core_clk_in,
	input  wire logic          wr_in,
	input  wire logic          erase_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [7:0]    wdata_in,
	output logic      [7:0]    rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [1024];
	// known preload pattern, shared with the bench model
	initial for (int i = 0; i < 1024; i++) mem[i] = 8'h5A ^ i[7:0];
	assign rdata_out = mem[addr_in[9:0]];
	// commits can only clear bits; erase sets a whole page
	always @(posedge core_clk_in) begin
		if (wr_in) mem[addr_in[9:0]] <= wdata_in & mem[addr_in[9:0]];
		if (erase_in) for (int i = 0; i < 512; i++) mem[{addr_in[9], i[8:0]}] <= 8'hFF;
	end
endmodule : fwec_flash_model

// ==== sim/fwec_chk.sv ====
module fwec_chk #(
	parameter int AW = 17
) (
	input wire logic          core_clk_in,
	input wire logic          nrst_in,
	input wire logic          por_in,
	input wire logic          mov_wr_in,
	input wire logic          mov_short_in,
	input wire logic [AW-1:0] mov_addr_in,
	input wire logic          dbg_wr_in,
	input wire logic          dbg_erase_in,
	input wire logic [7:0]    flash_rdata_in,
	input wire logic          flash_wr_out,
	input wire logic          flash_erase_out,
	input wire logic [AW-1:0] flash_addr_out,
	input wire logic [7:0]    flash_wdata_out,
	input wire logic          ram_wr_out,
	input wire logic          stall_out,
	input wire logic          mon_high_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	// calibration stall after reset, then release
	sequence s_cal;
		stall_out [*8];
	endsequence
	sequence s_free;
		##[1:20] !stall_out;
	endsequence
	logic quiet;
	assign quiet = !stall_out && !dbg_wr_in && !dbg_erase_in;
	property p_cal;
		$rose(nrst_in) |=> s_cal ##0 s_free;
	endproperty
	property p_erase_ff;
		flash_erase_out |-> flash_wdata_out == 8'hFF;
	endproperty
	property p_align;
		flash_erase_out |-> flash_addr_out[8:0] == 9'h000;
	endproperty
	property p_short;
		mov_wr_in && mov_short_in && mov_addr_in > 'hFF && quiet |=> !stall_out;
	endproperty
	property p_stall_op;
		flash_wr_out || flash_erase_out |-> stall_out;
	endproperty
	property p_release;
		flash_wr_out || flash_erase_out |-> ##[1:2] !stall_out;
	endproperty
	property p_wdata;
		flash_wr_out |-> (flash_wdata_out & ~flash_rdata_in) == 8'h00;
	endproperty
	property p_ram;
		ram_wr_out && quiet |-> mov_wr_in ##1 !stall_out;
	endproperty
	property p_mon;
		$fell(por_in) |-> !mon_high_out;
	endproperty
	a_cal: assert property (p_cal) else $error("no calibration stall");
	a_erase_ff: assert property (p_erase_ff) else $error("erase data not FF");
	a_align: assert property (p_align) else $error("erase not page aligned");
	a_short: assert property (p_short) else $error("short move reached flash");
	a_stall_op: assert property (p_stall_op) else $error("strobe without stall");
	a_release: assert property (p_release) else $error("stall not released");
	a_wdata: assert property (p_wdata) else $error("write sets a bit");
	a_ram: assert property (p_ram) else $error("ram move started op");
	a_mon: assert property (p_mon) else $error("monitor high after por");
endmodule : fwec_chk

// ==== sim/testbench.sv ====
`include "fwec_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 17;
	localparam int WR_CYC = 8;
	localparam int ER_CYC = 20;
	logic core_clk_in, nrst_in, por_in, initialized_in, reg_lo_cal_in, sfr_wr_in;
	logic mov_wr_in, mov_short_in, dbg_wr_in, dbg_erase_in, flash_wr_out, flash_erase_out;
	logic ram_wr_out, stall_out, hold_reset_out, mon_high_out;
	logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rd_addr_in, sfr_rdata_out, mov_data_in;
	logic [7:0] dbg_data_in, flash_rdata_in, flash_wdata_out, d;
	logic [AW-1:0] mov_addr_in, dbg_addr_in, flash_addr_out;
	logic [9:0] a;
	logic [7:0] model_mem [1024];
	int miscompares = 0, check_count = 0, seed = 83753, r;
	fwec_ctrl #(.AW(AW), .WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC)) u_dut (.*);
	fwec_flash_model #(.AW(AW)) u_flash (.core_clk_in(core_clk_in), .wr_in(flash_wr_out),
		.erase_in(flash_erase_out), .addr_in(flash_addr_out), .wdata_in(flash_wdata_out),
		.rdata_out(flash_rdata_in));
	task automatic chk(input logic [AW-1:0] seen, input logic [AW-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic sfr(input logic [7:0] ad, input logic [7:0] dd);
		@(negedge core_clk_in);
		{sfr_addr_in, sfr_wdata_in, sfr_wr_in} = {ad, dd, 1'b1};
		@(negedge core_clk_in);
		sfr_wr_in = 1'b0;
	endtask : sfr
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		@(negedge core_clk_in);
		sfr_rd_addr_in = ad;
		#1 chk(sfr_rdata_out, e);
	endtask : rd
	task automatic mov(input logic [AW-1:0] ad, input logic [7:0] dd, input logic s);
		@(negedge core_clk_in);
		{mov_addr_in, mov_data_in, mov_short_in, mov_wr_in} = {ad, dd, s, 1'b1};
		#1 if (s) chk(ram_wr_out, 1'b0);
		@(negedge core_clk_in);
		mov_wr_in = 1'b0;
	endtask : mov
	// waits for the commit strobe and checks the operation length
	task automatic wait_op(input int e);
		int n;
		for (n = 0; n < 100 && flash_wr_out !== 1'b1 && flash_erase_out !== 1'b1; n++)
			@(negedge core_clk_in);
		chk(flash_wr_out | flash_erase_out, 1'b1);
		chk(AW'(n), AW'(e));
		chk(stall_out, 1'b1);
	endtask : wait_op
	task automatic rst_dut;
		nrst_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		{nrst_in, por_in} = 2'b10;
		@(negedge core_clk_in);
		chk(stall_out, 1'b1);
		repeat (20) @(negedge core_clk_in);
		chk(stall_out, 1'b0);
	endtask : rst_dut
	task automatic keys;
		sfr(`FWEC_ADDR_KEY, `FWEC_KEY_FIRST);
		repeat (r[22:20]) @(negedge core_clk_in);
		sfr(`FWEC_ADDR_KEY, `FWEC_KEY_SECOND);
	endtask : keys
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// clock
	initial begin
		core_clk_in = 1'b0;
		forever #2.5 core_clk_in = ~core_clk_in;
	end
	// watchdog
	initial begin
		repeat (4000) @(posedge core_clk_in);
		miscompares++;
		wrap_up();
	end
	// main sequence
	initial begin
		{nrst_in, por_in, initialized_in, reg_lo_cal_in, sfr_wr_in, mov_wr_in} = 6'b011000;
		{mov_short_in, dbg_wr_in, dbg_erase_in, sfr_addr_in, sfr_wdata_in} = '0;
		{sfr_rd_addr_in, mov_data_in, dbg_data_in, mov_addr_in, dbg_addr_in} = '0;
		for (int i = 0; i < 1024; i++) model_mem[i] = 8'h5A ^ i[7:0];
		rst_dut();
		chk(mon_high_out, 1'b0);
		// threshold retune with the monitor out of the reset sources
		sfr(`FWEC_ADDR_RESET_SOURCE_REGISTER, 8'h04);
		sfr(`FWEC_ADDR_PAGE, `FWEC_PAGE_LVL);
		rd(`FWEC_ADDR_LVL_LOW, `FWEC_RST_LVL_LOW);
		sfr(`FWEC_ADDR_LVL_HIGH, `FWEC_RST_LVL_LOW);
		rd(`FWEC_ADDR_LVL_HIGH, `FWEC_RST_LVL_LOW);
		sfr(`FWEC_ADDR_PAGE, 8'h00);
		repeat (4) @(negedge core_clk_in);
		sfr(`FWEC_ADDR_RESET_SOURCE_REGISTER, 8'h06);
		rd(`FWEC_ADDR_RESET_SOURCE_REGISTER, 8'h06);
		sfr(`FWEC_ADDR_LVL_LOW, 8'h80);
		chk(mon_high_out, 1'b1);
		sfr(`FWEC_ADDR_SCALE, 8'h10);
		rd(`FWEC_ADDR_SCALE, 8'h10);
		// one erase then random byte writes
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			{d, a} = r[17:0];
			sfr(`FWEC_ADDR_PROGRAM_STORE_CONTROL, (k == 0) ? 8'h03 : 8'h01);
			keys();
			rd(`FWEC_ADDR_KEY, 8'h01);
			mov({7'h00, a}, d, 1'b0);
			wait_op((k == 0) ? ER_CYC : WR_CYC);
			if (k == 0) begin
				chk(flash_erase_out, 1'b1);
				chk(flash_addr_out, {a[9], 9'h000});
				for (int i = 0; i < 512; i++) model_mem[{a[9], i[8:0]}] = 8'hFF;
			end else begin
				chk(flash_wr_out, 1'b1);
				chk(flash_addr_out, a);
				chk(flash_wdata_out, d & model_mem[a]);
				model_mem[a] = d & model_mem[a];
			end
			repeat (2) @(negedge core_clk_in);
			chk(stall_out, 1'b0);
			rd(`FWEC_ADDR_KEY, 8'h00);
		end
		keys();
		mov(17'h00100, 8'h00, 1'b1);
		repeat (3) @(negedge core_clk_in);
		chk(stall_out, 1'b0);
		rd(`FWEC_ADDR_KEY, 8'h01);
		mov(17'h00010, d, 1'b1);
		wait_op(WR_CYC);
		chk(flash_wdata_out, d & model_mem[16]);
		model_mem[16] = d & model_mem[16];
		sfr(`FWEC_ADDR_PROGRAM_STORE_CONTROL, 8'h00);
		// write enable clear: the move goes to data memory
		@(negedge core_clk_in);
		{mov_addr_in, mov_data_in, mov_short_in, mov_wr_in} = {17'h00020, d, 1'b0, 1'b1};
		#1 chk(ram_wr_out, 1'b1);
		@(negedge core_clk_in);
		mov_wr_in = 1'b0;
		#1 chk(ram_wr_out, 1'b0);
		chk(stall_out, 1'b0);
		initialized_in = 1'b0;
		sfr(`FWEC_ADDR_PROGRAM_STORE_CONTROL, 8'h01);
		keys();
		mov(17'h00030, 8'h00, 1'b0);
		repeat (3) @(negedge core_clk_in);
		chk(stall_out, 1'b0);
		{dbg_addr_in, dbg_data_in, dbg_wr_in} = {17'h00021, d, 1'b1};
		@(negedge core_clk_in);
		dbg_wr_in = 1'b0;
		wait_op(WR_CYC);
		chk(flash_wdata_out, d & model_mem[33]);
		model_mem[33] = d & model_mem[33];
		// debug page erase once the write has retired
		@(negedge core_clk_in);
		dbg_erase_in = 1'b1;
		@(negedge core_clk_in);
		dbg_erase_in = 1'b0;
		wait_op(ER_CYC);
		chk(flash_erase_out, 1'b1);
		chk(flash_addr_out, 17'h00000);
		for (int i = 0; i < 512; i++) model_mem[i] = 8'hFF;
		initialized_in = 1'b1;
		rst_dut();
		sfr(`FWEC_ADDR_PROGRAM_STORE_CONTROL, 8'h01);
		mov(17'h00040, 8'h00, 1'b0);
		rd(`FWEC_ADDR_KEY, 8'h02);
		keys();
		rd(`FWEC_ADDR_KEY, 8'h02);
		for (int j = 0; j < 2; j++) begin
			rst_dut();
			if (j == 1) sfr(`FWEC_ADDR_KEY, `FWEC_KEY_FIRST);
			sfr(`FWEC_ADDR_KEY, (j == 1) ? 8'h3C : `FWEC_KEY_SECOND);
			rd(`FWEC_ADDR_KEY, 8'h02);
		end
		// a move in lockout must not start an operation
		sfr(`FWEC_ADDR_PROGRAM_STORE_CONTROL, 8'h01);
		mov(17'h00050, 8'h00, 1'b0);
		repeat (2) @(negedge core_clk_in);
		chk(stall_out, 1'b0);
		reg_lo_cal_in = 1'b1;
		repeat (3) @(negedge core_clk_in);
		nrst_in = 1'b0;
		repeat (3) @(negedge core_clk_in);
		chk(hold_reset_out, 1'b1);
		por_in = 1'b1;
		rst_dut();
		chk(hold_reset_out, 1'b0);
		chk(mon_high_out, 1'b0);
		wrap_up();
	end
endmodule : testbench
bind fwec_ctrl fwec_chk #(.AW(AW)) u_chk (.*);
